/* File: logic/tx_test_consts.svh */
// Purpose: constants of the transmit test pattern generator
// Assumes: 16-bit register port, word indexed
// Notes:   offsets are register indices on the plain port
//
// Contract
// - carrier mode: field 2, 0x1800 to DAC reg, tx-on; DAC held static.
// - field 3 plus tx-on with an empty queue sends the CRC pseudorandom byte stream.
// - each byte is CRC low byte; CRC then advances by feeding 0xFF.
// - the pseudorandom sequence repeats every 65535 bits.
// - stream after header starts 0x00, 0x78, 0xb8, 0x4b, 0x99, 0xc3, 0xe9.
// - every transmit mode except carrier sends preamble and SFD before the data.
// - loaded queue with field 3 replays the queue, ignoring underflow.
// - queue replay repeats every 1024 bits, the whole 128-byte queue.
// - bias switch output low in receive, high in transmit.
`ifndef TX_TEST_CONSTS_SVH
`define TX_TEST_CONSTS_SVH
`define REG_MAIN_CTRL      6'h00
`define REG_MODEM_CTRL_ONE 6'h01
`define REG_DAC_OVERRIDE   6'h02
`define REG_STATUS         6'h03
`define REG_QUEUE_WRITE    6'h04
`define REG_OSC_ON_STROBE  6'h08
`define REG_TX_ON_STROBE   6'h09
`define REG_RF_OFF_STROBE  6'h0A
`define BIT_REF_BYPASS     0
`define TX_MODE_LSB        2
`define TX_MODE_CARRIER    2'h2
`define TX_MODE_TEST       2'h3
`define CRC_FEED_BYTE      8'hFF
`define CRC_POLY_REFLECTED 16'h8408
`define CRC_INIT           16'h0000
`define PREAMBLE_BYTE      8'h00
`define SFD_BYTE           8'hA7
`define PREAMBLE_LEN       4
`define QUEUE_DEPTH        128
`endif

/* File: logic/tx_test_pkg.sv */
// Purpose: types of the transmit test pattern generator
// Assumes: nothing
// Notes:   constants live in the header
package tx_test_pkg;
  typedef enum logic [1:0] {st_idle, st_header, st_payload, st_carrier} tx_state_t;
  typedef logic [1:0] tx_mode_t;
endpackage

/* File: logic/tx_test_pattern_gen.sv */
// Purpose: transmit test modes: carrier override, CRC pattern, queue replay
// Assumes: host keeps the oscillator start-up order and the 16 MHz reference
// Notes:   byte stream handed to the modem by valid/ready
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tx_test_consts.svh"
module tx_test_pattern_gen #(
  parameter int PREAMBLE_BYTES = `PREAMBLE_LEN,
  parameter int QUEUE_BYTES    = `QUEUE_DEPTH
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // register port
  input  wire logic [5:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata,
  // oscillator
  input  wire logic              osc_stable,
  output logic                   ref_clock_bypass_bit,
  // modem byte stream
  output logic [7:0]             tx_byte,
  output logic                   tx_byte_valid,
  input  wire logic              tx_byte_ready,
  // analog controls
  output logic [15:0]            dac_override_value,
  output logic                   dac_override_en,
  output logic                   rf_bias_switch_out
);
  import tx_test_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  // header counter is 4 bits and the queue pointers are sized for 128 slots
  if (QUEUE_BYTES != 128 || PREAMBLE_BYTES < 1 || PREAMBLE_BYTES > 15)
  begin
    $error("tx_test_pattern_gen: unsupported parameter values");
  end

  // ****************************************
  // crc byte step, lsb first
  // ****************************************
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      fb = r[0] ^ d[i];
      r  = {1'b0, r[15:1]};
      if (fb)
        r = r ^ `CRC_POLY_REFLECTED;
    end
    return r;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  queue_mem [QUEUE_BYTES];
  tx_state_t   state_ff,   nxt_state;
  logic        bypass_ff,  nxt_bypass;
  tx_mode_t    mode_ff,    nxt_mode;
  logic [15:0] dac_ff,     nxt_dac;
  logic        osc_on_ff,  nxt_osc_on;
  logic        undfl_ff,   nxt_undfl;
  logic [7:0]  wptr_ff,    nxt_wptr;
  logic [6:0]  rptr_ff,    nxt_rptr;
  logic        replay_ff,  nxt_replay;
  logic [3:0]  hdr_ff,     nxt_hdr;
  logic [15:0] crc_ff,     nxt_crc;
  logic [7:0]  byte_ff,    nxt_byte;
  logic        valid_ff,   nxt_valid;
  logic [15:0] rdata_ff,   nxt_rdata;
  logic        bias_ff,    nxt_bias;
  logic        ovr_ff,     nxt_ovr;
  logic        wr_queue;
  logic        take;
  logic        queue_full;

  assign take       = valid_ff & tx_byte_ready;
  assign queue_full = wptr_ff[7];
  assign wr_queue   = reg_wr & (reg_addr == `REG_QUEUE_WRITE) & ~queue_full
                      & (state_ff == st_idle);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_bypass = bypass_ff;
    nxt_mode   = mode_ff;
    nxt_dac    = dac_ff;
    nxt_osc_on = osc_on_ff;
    nxt_undfl  = undfl_ff;
    nxt_wptr   = wptr_ff;
    nxt_rptr   = rptr_ff;
    nxt_replay = replay_ff;
    nxt_hdr    = hdr_ff;
    nxt_crc    = crc_ff;
    nxt_byte   = byte_ff;
    nxt_valid  = valid_ff;
    nxt_rdata  = 16'h0000;
    if (wr_queue)
      nxt_wptr = wptr_ff + 8'h01;
    if (reg_wr)
    begin
      case (reg_addr)
        `REG_MAIN_CTRL:      nxt_bypass = reg_wdata[`BIT_REF_BYPASS];
        `REG_MODEM_CTRL_ONE: nxt_mode   = reg_wdata[`TX_MODE_LSB +: 2];
        `REG_DAC_OVERRIDE:   nxt_dac    = reg_wdata;
        `REG_OSC_ON_STROBE:  nxt_osc_on = 1'b1;
        default:             nxt_osc_on = nxt_osc_on;
      endcase
    end
    case (state_ff)
      st_idle:
      begin
        nxt_valid = 1'b0;
        if (reg_wr && reg_addr == `REG_TX_ON_STROBE)
        begin
          nxt_undfl  = 1'b0;
          nxt_rptr   = 7'h00;
          nxt_crc    = `CRC_INIT;
          nxt_replay = (wptr_ff != 8'h00);
          if (mode_ff == `TX_MODE_CARRIER)
            nxt_state = st_carrier;
          else
          begin
            nxt_state = st_header;
            nxt_hdr   = 4'h0;
            nxt_byte  = `PREAMBLE_BYTE;
            nxt_valid = 1'b1;
          end
        end
      end
      st_header:
      begin
        if (take)
        begin
          nxt_hdr = hdr_ff + 4'h1;
          if (hdr_ff < 4'(PREAMBLE_BYTES - 1))
            nxt_byte = `PREAMBLE_BYTE;
          else if (hdr_ff == 4'(PREAMBLE_BYTES - 1))
            nxt_byte = `SFD_BYTE;
          else
          begin
            nxt_state = st_payload;
            if (mode_ff == `TX_MODE_TEST && !replay_ff)
            begin
              nxt_byte = crc_ff[7:0];
              nxt_crc  = crc_step(crc_ff, `CRC_FEED_BYTE);
            end
            else if (wptr_ff == 8'h00)
            begin
              nxt_state = st_idle;
              nxt_undfl = 1'b1;
              nxt_valid = 1'b0;
            end
            else
            begin
              nxt_byte = queue_mem[7'h00];
              nxt_rptr = 7'h01;
            end
          end
        end
      end
      st_payload:
      begin
        if (take)
        begin
          if (mode_ff == `TX_MODE_TEST && !replay_ff)
          begin
            nxt_byte = crc_ff[7:0];
            nxt_crc  = crc_step(crc_ff, `CRC_FEED_BYTE);
          end
          else if (mode_ff == `TX_MODE_TEST)
          begin
            // unwritten slots replay too, so the loop is always 128 bytes
            nxt_byte = queue_mem[rptr_ff];
            nxt_rptr = rptr_ff + 7'h01;
          end
          else if ({1'b0, rptr_ff} == wptr_ff || (rptr_ff == 7'h00 && queue_full))
          begin
            nxt_state = st_idle;
            nxt_valid = 1'b0;
            nxt_undfl = 1'b1;
          end
          else
          begin
            nxt_byte = queue_mem[rptr_ff];
            nxt_rptr = rptr_ff + 7'h01;
          end
        end
      end
      st_carrier:
        nxt_valid = 1'b0;
      default:
        nxt_state = st_idle;
    endcase
    if (reg_wr && reg_addr == `REG_RF_OFF_STROBE)
    begin
      nxt_state = st_idle;
      nxt_valid = 1'b0;
      nxt_wptr  = 8'h00;
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `REG_MAIN_CTRL:      nxt_rdata = {15'h0000, bypass_ff};
        `REG_MODEM_CTRL_ONE: nxt_rdata = {12'h000, mode_ff, 2'h0};
        `REG_DAC_OVERRIDE:   nxt_rdata = dac_ff;
        `REG_STATUS:         nxt_rdata = {8'h00, wptr_ff[7:0]} | {9'h000, state_ff,
                                          undfl_ff, osc_stable, osc_on_ff, 2'h0} << 8;
        default:             nxt_rdata = 16'h0000;
      endcase
    end
    nxt_bias = (nxt_state != st_idle);
    nxt_ovr  = (nxt_state == st_carrier);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff  <= st_idle;
      bypass_ff <= 1'b0;
      mode_ff   <= 2'h0;
      dac_ff    <= 16'h0000;
      osc_on_ff <= 1'b0;
      undfl_ff  <= 1'b0;
      wptr_ff   <= 8'h00;
      rptr_ff   <= 7'h00;
      replay_ff <= 1'b0;
      hdr_ff    <= 4'h0;
      crc_ff    <= `CRC_INIT;
      byte_ff   <= 8'h00;
      valid_ff  <= 1'b0;
      rdata_ff  <= 16'h0000;
      bias_ff   <= 1'b0;
      ovr_ff    <= 1'b0;
    end
    else if (ce)
    begin
      state_ff  <= nxt_state;
      bypass_ff <= nxt_bypass;
      mode_ff   <= nxt_mode;
      dac_ff    <= nxt_dac;
      osc_on_ff <= nxt_osc_on;
      undfl_ff  <= nxt_undfl;
      wptr_ff   <= nxt_wptr;
      rptr_ff   <= nxt_rptr;
      replay_ff <= nxt_replay;
      hdr_ff    <= nxt_hdr;
      crc_ff    <= nxt_crc;
      byte_ff   <= nxt_byte;
      valid_ff  <= nxt_valid;
      rdata_ff  <= nxt_rdata;
      bias_ff   <= nxt_bias;
      ovr_ff    <= nxt_ovr;
    end
  end

  // queue storage has no reset; contents are defined by host writes
  always_ff @(posedge mclk)
  begin
    if (ce && wr_queue)
      queue_mem[wptr_ff[6:0]] <= reg_wdata[7:0];
  end

  assign reg_rdata            = rdata_ff;
  assign ref_clock_bypass_bit = bypass_ff;
  assign tx_byte              = byte_ff;
  assign tx_byte_valid        = valid_ff;
  assign dac_override_value   = dac_ff;
  assign dac_override_en      = ovr_ff;
  assign rf_bias_switch_out   = bias_ff;
endmodule
`default_nettype wire

/* File: verification/tx_test_chk.sv */
// Purpose: port assertions for tx_test_pattern_gen
// Assumes: ce high
// Notes:   bound after endmodule
`timescale 1ns/1ps
`default_nettype none
`include "tx_test_consts.svh"
module tx_test_chk #(
  parameter int PREAMBLE_BYTES = `PREAMBLE_LEN,
  parameter int QUEUE_BYTES    = `QUEUE_DEPTH
) (
  // clock, reset, register port
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic [5:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  // outputs and stream
  input wire logic        ref_clock_bypass_bit,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_byte_valid,
  input wire logic        tx_byte_ready,
  input wire logic [15:0] dac_override_value,
  input wire logic        dac_override_en,
  input wire logic        rf_bias_switch_out
);
  // ****
  // assertions
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic wr_ok;
  assign wr_ok = reg_wr && ce;
  a_byte_hold: assert property (tx_byte_valid && !tx_byte_ready
    && !(wr_ok && reg_addr == `REG_RF_OFF_STROBE)
    |=> tx_byte_valid && $stable(tx_byte))
    else $error("byte changed before accept");
  a_bias_stream: assert property (tx_byte_valid |-> rf_bias_switch_out)
    else $error("stream without tx bias");
  a_carrier_quiet: assert property (dac_override_en |-> rf_bias_switch_out && !tx_byte_valid)
    else $error("carrier state wrong");
  a_carrier_static: assert property (dac_override_en
    && !(wr_ok && reg_addr == `REG_DAC_OVERRIDE) |=> $stable(dac_override_value))
    else $error("dac value moved");
  a_tx_start: assert property (wr_ok && reg_addr == `REG_TX_ON_STROBE
    && !rf_bias_switch_out |=> rf_bias_switch_out)
    else $error("tx-on ignored in idle");
  a_hdr_first: assert property ($rose(rf_bias_switch_out) && tx_byte_valid
    |-> tx_byte == `PREAMBLE_BYTE)
    else $error("stream not opened by preamble");
  a_stop_idle: assert property (wr_ok && reg_addr == `REG_RF_OFF_STROBE
    |=> !rf_bias_switch_out && !tx_byte_valid)
    else $error("rf-off did not stop");
  a_bypass_set: assert property (wr_ok && reg_addr == `REG_MAIN_CTRL
    |=> ref_clock_bypass_bit == $past(reg_wdata[`BIT_REF_BYPASS]))
    else $error("bypass bit not taken");
endmodule
bind tx_test_pattern_gen tx_test_chk #(.PREAMBLE_BYTES(PREAMBLE_BYTES), .QUEUE_BYTES(QUEUE_BYTES))
  u_chk (.mclk(mclk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .ref_clock_bypass_bit(ref_clock_bypass_bit), .tx_byte(tx_byte),
  .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
  .dac_override_value(dac_override_value), .dac_override_en(dac_override_en),
  .rf_bias_switch_out(rf_bias_switch_out));
`default_nettype wire

/* File: verification/modem_sink.sv */
// Purpose: modem side taking stream bytes
// Assumes: valid held until taken
// Notes:   stalls one cycle in four so holds get exercised
`timescale 1ns/1ps
`default_nettype none
module modem_sink (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // stream
  output logic      tx_byte_ready
);
  logic [1:0] cnt_ff;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) cnt_ff <= 2'h0;
    else cnt_ff <= cnt_ff + 2'h1;
  assign tx_byte_ready = (cnt_ff != 2'h3);
endmodule
`default_nettype wire

/* File: verification/tx_test_pattern_gen_tb.sv */
// Purpose: self-checking bench for tx_test_pattern_gen
// Assumes: default parameters, ce tied high
// Notes:   expected bytes built from own crc and queue models
`timescale 1ns/1ps
`default_nettype none
`include "tx_test_consts.svh"
module tx_test_pattern_gen_tb;
  logic        mclk, nrst, ce, reg_wr, reg_rd, osc_stable, tx_byte_valid, tx_byte_ready;
  logic        ref_clock_bypass_bit, dac_override_en, rf_bias_switch_out;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, dac_override_value, crc;
  logic [7:0]  tx_byte, qm[$], got[$], exp[$];
  logic [31:0] rnd;
  logic [7:0]  spec[7] = '{8'h00, 8'h78, 8'hB8, 8'h4B, 8'h99, 8'hC3, 8'hE9};
  int          err_total, comparisons;
  tx_test_pattern_gen i_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_stable(osc_stable), .ref_clock_bypass_bit(ref_clock_bypass_bit), .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
    .dac_override_value(dac_override_value), .dac_override_en(dac_override_en),
    .rf_bias_switch_out(rf_bias_switch_out));
  modem_sink i_sink (.mclk(mclk), .nrst(nrst), .tx_byte_ready(tx_byte_ready));
  // ****
  // helpers
  // ****
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (tx_byte_valid === 1'b1 && tx_byte_ready) got.push_back(tx_byte);
  function automatic logic [31:0] lf(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] crc_upd(logic [15:0] c);
    logic [7:0] d;
    d = `CRC_FEED_BYTE;
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ `CRC_POLY_REFLECTED : c >> 1;
    return c;
  endfunction
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [5:0] a, logic [15:0] m, logic [15:0] e, string nm);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata & m, e);
  endtask
  task automatic hdr();
    // let the edge that stopped the last stream pass before clearing the capture
    @(posedge mclk);
    got.delete();
    exp.delete();
    repeat (`PREAMBLE_LEN) exp.push_back(`PREAMBLE_BYTE);
    exp.push_back(`SFD_BYTE);
  endtask
  task automatic run(int n, string nm);
    wr(`REG_TX_ON_STROBE, 16'h0000);
    for (int i = 0; i < 3000 && got.size() < n; i++) @(posedge mclk);
    for (int i = 0; i < n; i++) chk(nm, 16'(got[i]), 16'(exp[i]));
    $display("test %s done", nm);
  endtask
  task automatic print_verdict();
    $display("counts: %0d compared, %0d failed", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_total++;
    print_verdict();
  end
  // ****
  // tests
  // ****
  initial
  begin
    {nrst, reg_wr, reg_rd, osc_stable, reg_addr, reg_wdata} = '0;
    ce = 1'b1;
    rnd = 32'hE8BFF532;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd(`REG_STATUS, 16'hFFFF, 16'h0000, "status_rst");
    @(posedge mclk);
    osc_stable <= 1'b1;
    wr(`REG_OSC_ON_STROBE, 16'h0000);
    rd(`REG_STATUS, 16'hFFFF, 16'h0C00, "status_osc");
    wr(`REG_MAIN_CTRL, 16'h0001);
    #1 chk("bypass", 16'(ref_clock_bypass_bit), 16'h0001);
    rd(6'h3F, 16'hFFFF, 16'h0000, "unmapped");
    $display("test regs done");
    wr(`REG_MODEM_CTRL_ONE, 16'h0008);
    wr(`REG_DAC_OVERRIDE, 16'h1800);
    wr(`REG_TX_ON_STROBE, 16'h0000);
    @(posedge mclk);
    #1 chk("carrier", {dac_override_en, rf_bias_switch_out, tx_byte_valid, 13'h0}, 16'hC000);
    chk("dac", dac_override_value, 16'h1800);
    wr(`REG_RF_OFF_STROBE, 16'h0000);
    #1 chk("bias_off", 16'(rf_bias_switch_out), 16'h0000);
    $display("test carrier done");
    wr(`REG_MODEM_CTRL_ONE, 16'h000C);
    hdr();
    crc = `CRC_INIT;
    repeat (40)
    begin
      exp.push_back(crc[7:0]);
      crc = crc_upd(crc);
    end
    run(45, "crc");
    for (int i = 0; i < 7; i++) chk("crc_head", 16'(got[5 + i]), 16'(spec[i]));
    wr(`REG_RF_OFF_STROBE, 16'h0000);
    hdr();
    for (int i = 0; i < 129; i++)
    begin
      rnd = lf(rnd);
      wr(`REG_QUEUE_WRITE, rnd[15:0]);
      if (i < 128) qm.push_back(rnd[7:0]);
    end
    rd(`REG_STATUS, 16'h00FF, 16'h0080, "queue_full");
    for (int i = 0; i < 260; i++) exp.push_back(qm[i % 128]);
    run(265, "replay");
    rd(`REG_STATUS, 16'hF800, 16'h4800, "replay_state");
    wr(`REG_RF_OFF_STROBE, 16'h0000);
    wr(`REG_MODEM_CTRL_ONE, 16'h0000);
    hdr();
    wr(`REG_QUEUE_WRITE, 16'h005A);
    wr(`REG_QUEUE_WRITE, 16'h00C3);
    exp.push_back(8'h5A);
    exp.push_back(8'hC3);
    run(7, "normal");
    repeat (10) @(posedge mclk);
    chk("no_extra", 16'(got.size()), 16'h0007);
    rd(`REG_STATUS, 16'hF800, 16'h1800, "underflow");
    chk("bias_idle", 16'(rf_bias_switch_out), 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
